// ### include/pshp_params.svh
`ifndef PSHP_PARAMS_SVH
`define PSHP_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// register offsets on the plain register port
`define PSHP_ADDR_W 4
`define PSHP_OFS_CTRL 4'h0
`define PSHP_OFS_LATCH 4'h1
`define PSHP_OFS_DATA_A 4'h2
`define PSHP_OFS_DIR 4'h3
`define PSHP_OFS_PORTC 4'h4
`define PSHP_OFS_IRQ_STAT 4'h5
`define PSHP_OFS_IRQ_CLR 4'h6
`define PSHP_OFS_IRQ_EN 4'h7

////////////////////////////////////////////////////////////////////////////////
// handshake control field positions
`define PSHP_CTRL_FLAG 7
`define PSHP_CTRL_IRQ_EN 6
`define PSHP_CTRL_OPEN_DRAIN 5
`define PSHP_CTRL_FULL_HS 4
`define PSHP_CTRL_OUT_IN 3
`define PSHP_CTRL_PULSED 2
`define PSHP_CTRL_EDGE 1
`define PSHP_CTRL_STROBE_B_INVERT 0

// interrupt status bit positions
`define PSHP_IRQ_EDGE 0
`define PSHP_IRQ_DONE 1

////////////////////////////////////////////////////////////////////////////////
// reset values
`define PSHP_CTRL_RESET 8'h00
`define PSHP_DIR_RESET 8'h00
`define PSHP_BYTE_RESET 8'h00
`define PSHP_IRQ_RESET 2'h0

////////////////////////////////////////////////////////////////////////////////
// timing
`define PSHP_CLK_PERIOD_NS 10
`define PSHP_STROBE_B_OUT_PULSE_NS 20
`define PSHP_STROBE_B_OUT_PULSE_CYC \
  ((`PSHP_STROBE_B_OUT_PULSE_NS + `PSHP_CLK_PERIOD_NS - 1) / `PSHP_CLK_PERIOD_NS)

`endif

// ### include/pshp_pkg.sv
package pshp_pkg;

  // handshake operating mode
  typedef enum logic [1:0] {
    PSHP_MODE_SIMPLE = 2'b00,
    PSHP_MODE_IN_HS = 2'b01,
    PSHP_MODE_OUT_HS = 2'b10,
    PSHP_MODE_OFF = 2'b11
  } pshp_mode_t;

  // whole register state of the port
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] latch;
    logic [7:0] data_a;
    logic [7:0] dir;
    logic [7:0] portc;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic [7:0] rdata;
    logic strobe_b_out_level;
    logic [1:0] pulse_cnt;
    logic flag_armed;
  } pshp_state_t;

endpackage

// ### hw/pshp_strobe_sync.sv
`timescale 1ns/100ps
`default_nettype none

// two-stage synchroniser plus edge detector for the strobe A pin
module pshp_strobe_sync (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // raw pin
  input wire logic pin_in,
  // synchronised level and one-cycle edge pulses
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta_reg; // first stage, read only by sync_reg
  logic sync_reg; // second stage
  logic prev_reg; // delayed copy for edge detection

  ////////////////////////////////////////////////////////////////////////////
  // synchroniser chain
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge pulses from the second and third stages only
  assign level = sync_reg;
  assign rise = sync_reg & ~prev_reg;
  assign fall = ~sync_reg & prev_reg;

endmodule

`default_nettype wire

// ### hw/pshp_port.sv
`timescale 1ns/100ps
`default_nettype none

`include "pshp_params.svh"

// Functional notes
// R1: handshake logic works only in single-chip mode
// R2: control register read/write except read-only flag
// R3: selected strobe A edge sets the flag
// R4: flag clears after control read then latch access
// R5: flag requests interrupt when its enable set
// R6: open-drain selection makes port C drive low only
// R7: mode bit picks simple or full handshake
// R8: direction bit picks input/output, only in handshake
// R9: interlocked: strobe B active until strobe A edge
// R10: pulsed: strobe B active exactly two cycles
// R11: edge bit picks edge and driver enable level
// R12: invert bit sets strobe B active level
// R13: simple mode: data write pulses strobe B
// R14: input handshake ready, latch, negate, reassert on read
// R15: output handshake: latch write asserts strobe B
// R16: three-state output: strobe A drives all port C
// R17: strobe A synchronised before edge detection
module pshp_port
  import pshp_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // chip operating mode
  input wire logic SINGLE_CHIP_MODE,
  // register port
  input wire logic [`PSHP_ADDR_W-1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // strobe pins
  input wire logic STROBE_A_IN_IN,
  output logic STROBE_B_OUT_OUT,
  // port B data
  output logic [7:0] DATA_REG_A_OUT,
  // port C two-way pins
  input wire logic [7:0] PORTC_IN,
  output logic [7:0] PORTC_OUT,
  output logic [7:0] PORTC_OE_N,
  // interrupts
  output logic STROBE_A_IN_IRQ,
  output logic IRQ
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations
  pshp_state_t r_reg; // registered state
  pshp_state_t r_next; // next state
  pshp_mode_t mode; // decoded operating mode
  logic strobe_a_in_level; // synchronised strobe A
  logic strobe_a_in_rise; // rising edge pulse
  logic strobe_a_in_fall; // falling edge pulse
  logic sel_edge; // selected strobe A edge this cycle
  logic strobe_a_in_drive; // strobe A at driver-enable level
  logic wr_ctrl; // write to control register
  logic rd_ctrl; // read of control register
  logic rd_latch; // read of latch register
  logic wr_latch; // write to latch register
  logic wr_data_a; // write to port B data
  logic flag_clear; // clearing sequence complete
  logic strobe_b_out_active; // strobe B at active level
  logic [7:0] drv_data; // port C data to drive
  logic [7:0] drv_en; // port C bits driven
  logic [7:0] ctrl_new; // control value after a write
  logic in_hs_entry; // control write enters input handshake
  logic hs_done; // strobe B negated by the partner

  //////////////////////////////////////////////////////////////////////////////
  // strobe A synchroniser
  pshp_strobe_sync u_sync (
    .clk(CLK),
    .srst(SRST),
    .pin_in(STROBE_A_IN_IN),
    .level(strobe_a_in_level),
    .rise(strobe_a_in_rise),
    .fall(strobe_a_in_fall)
  );

  //////////////////////////////////////////////////////////////////////////////
  // mode and strobe decode
  always_comb begin
    // single-chip gates all handshake behaviour
    if (!SINGLE_CHIP_MODE) begin // R1
      mode = PSHP_MODE_OFF;
    end else if (!r_reg.ctrl[`PSHP_CTRL_FULL_HS]) begin // R7
      mode = PSHP_MODE_SIMPLE;
    end else if (r_reg.ctrl[`PSHP_CTRL_OUT_IN]) begin // R8
      mode = PSHP_MODE_OUT_HS;
    end else begin
      mode = PSHP_MODE_IN_HS;
    end
  end

  // edge choice and driver-enable level from the edge bit
  assign sel_edge = r_reg.ctrl[`PSHP_CTRL_EDGE] ? strobe_a_in_rise
                                                : strobe_a_in_fall; // R11 R17
  assign strobe_a_in_drive = r_reg.ctrl[`PSHP_CTRL_EDGE] ? ~strobe_a_in_level
                                                  : strobe_a_in_level; // R11

  //////////////////////////////////////////////////////////////////////////////
  // register port strobes
  always_comb begin
    // default: no access
    wr_ctrl = 1'b0;
    rd_ctrl = 1'b0;
    rd_latch = 1'b0;
    wr_latch = 1'b0;
    wr_data_a = 1'b0;
    if (ADDR == `PSHP_OFS_CTRL) begin
      wr_ctrl = WR;
      rd_ctrl = RD;
    end else if (ADDR == `PSHP_OFS_LATCH) begin
      wr_latch = WR;
      rd_latch = RD;
    end else if (ADDR == `PSHP_OFS_DATA_A) begin
      wr_data_a = WR;
    end
  end

  // control value a write would leave, flag bit kept
  assign ctrl_new = {r_reg.ctrl[`PSHP_CTRL_FLAG], WDATA[6:0]}; // R2
  assign in_hs_entry = wr_ctrl & WDATA[`PSHP_CTRL_FULL_HS]
                     & ~WDATA[`PSHP_CTRL_OUT_IN]
                     & (mode != PSHP_MODE_IN_HS) & SINGLE_CHIP_MODE;

  // second half of the flag clearing sequence, per mode
  always_comb begin
    // default: no clear
    flag_clear = 1'b0;
    if (r_reg.flag_armed) begin
      if (mode == PSHP_MODE_OUT_HS) begin
        flag_clear = wr_latch; // R4
      end else begin
        flag_clear = rd_latch; // R4
      end
    end
  end

  // partner completed a full handshake this cycle
  assign hs_done = sel_edge & r_reg.strobe_b_out_level
                 & ((mode == PSHP_MODE_IN_HS) | (mode == PSHP_MODE_OUT_HS));

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    r_next = r_reg;
    r_next.rdata = `PSHP_BYTE_RESET;
    // pulse countdown
    if (r_reg.pulse_cnt != 2'h0) begin
      r_next.pulse_cnt = r_reg.pulse_cnt - 2'h1; // R10
    end
    // control register writes, flag bit read-only
    if (wr_ctrl) begin
      r_next.ctrl = ctrl_new; // R2
    end
    // plain data registers
    if (WR && ADDR == `PSHP_OFS_DATA_A) begin
      r_next.data_a = WDATA;
    end
    if (WR && ADDR == `PSHP_OFS_DIR) begin
      r_next.dir = WDATA;
    end
    if (WR && ADDR == `PSHP_OFS_PORTC) begin
      r_next.portc = WDATA;
    end
    if (WR && ADDR == `PSHP_OFS_IRQ_EN) begin
      r_next.irq_en = WDATA[1:0];
    end
    // write-one-to-clear of interrupt status
    if (WR && ADDR == `PSHP_OFS_IRQ_CLR) begin
      r_next.irq_stat = r_reg.irq_stat & ~WDATA[1:0];
    end
    // latch writes load the latch in every mode, output handshake drives it out
    if (wr_latch) begin
      r_next.latch = WDATA;
    end
    // flag clearing sequence
    if (rd_ctrl && r_reg.ctrl[`PSHP_CTRL_FLAG]) begin
      r_next.flag_armed = 1'b1; // R4
    end
    if (flag_clear) begin
      r_next.ctrl[`PSHP_CTRL_FLAG] = 1'b0; // R4
      r_next.flag_armed = 1'b0;
    end
    // strobe B handling per mode
    case (mode)
      PSHP_MODE_SIMPLE: begin
        r_next.strobe_b_out_level = 1'b0;
        if (wr_data_a) begin
          r_next.pulse_cnt = 2'(`PSHP_STROBE_B_OUT_PULSE_CYC); // R13
        end
      end
      PSHP_MODE_IN_HS: begin
        // ready again after a latch read
        if (rd_latch) begin // R14
          if (r_reg.ctrl[`PSHP_CTRL_PULSED]) begin
            r_next.pulse_cnt = 2'(`PSHP_STROBE_B_OUT_PULSE_CYC); // R10
          end else begin
            r_next.strobe_b_out_level = 1'b1; // R9
          end
        end
        if (sel_edge) begin
          r_next.strobe_b_out_level = 1'b0; // R9 R14
        end
      end
      PSHP_MODE_OUT_HS: begin
        // data ready after a latch write
        if (wr_latch) begin // R15
          if (r_reg.ctrl[`PSHP_CTRL_PULSED]) begin
            r_next.pulse_cnt = 2'(`PSHP_STROBE_B_OUT_PULSE_CYC); // R10
          end else begin
            r_next.strobe_b_out_level = 1'b1; // R9
          end
        end
        // selected edge is the trailing edge of the active strobe A
        if (sel_edge) begin
          r_next.strobe_b_out_level = 1'b0; // R9 R16
        end
      end
      default: begin
        // not single-chip: strobe B idle
        r_next.strobe_b_out_level = 1'b0; // R1
        r_next.pulse_cnt = 2'h0;
      end
    endcase
    // control write entering input handshake signals ready at once
    if (in_hs_entry) begin // R14
      if (WDATA[`PSHP_CTRL_PULSED]) begin
        r_next.pulse_cnt = 2'(`PSHP_STROBE_B_OUT_PULSE_CYC); // R10
      end else begin
        r_next.strobe_b_out_level = 1'b1; // R9
      end
    end
    // selected strobe A edge: latch inputs except in output handshake, and set the flag
    if (sel_edge && mode != PSHP_MODE_OFF) begin // R1
      if (mode != PSHP_MODE_OUT_HS) begin
        r_next.latch = PORTC_IN; // R14
      end
      r_next.ctrl[`PSHP_CTRL_FLAG] = 1'b1; // R3
      r_next.irq_stat[`PSHP_IRQ_EDGE] = 1'b1;
    end
    // handshake completion event
    if (hs_done) begin
      r_next.irq_stat[`PSHP_IRQ_DONE] = 1'b1;
    end
    // registered read data
    if (RD) begin
      if (ADDR == `PSHP_OFS_CTRL) begin
        r_next.rdata = r_reg.ctrl; // R2
      end else if (ADDR == `PSHP_OFS_LATCH) begin
        r_next.rdata = r_reg.latch;
      end else if (ADDR == `PSHP_OFS_DATA_A) begin
        r_next.rdata = r_reg.data_a;
      end else if (ADDR == `PSHP_OFS_DIR) begin
        r_next.rdata = r_reg.dir;
      end else if (ADDR == `PSHP_OFS_PORTC) begin
        r_next.rdata = PORTC_IN;
      end else if (ADDR == `PSHP_OFS_IRQ_STAT) begin
        r_next.rdata = {6'h00, r_reg.irq_stat};
      end else if (ADDR == `PSHP_OFS_IRQ_EN) begin
        r_next.rdata = {6'h00, r_reg.irq_en};
      end else begin
        r_next.rdata = `PSHP_BYTE_RESET;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge CLK) begin
    if (SRST) begin
      r_reg.ctrl <= `PSHP_CTRL_RESET;
      r_reg.latch <= `PSHP_BYTE_RESET;
      r_reg.data_a <= `PSHP_BYTE_RESET;
      r_reg.dir <= `PSHP_DIR_RESET;
      r_reg.portc <= `PSHP_BYTE_RESET;
      r_reg.irq_stat <= `PSHP_IRQ_RESET;
      r_reg.irq_en <= `PSHP_IRQ_RESET;
      r_reg.rdata <= `PSHP_BYTE_RESET;
      r_reg.strobe_b_out_level <= 1'b0;
      r_reg.pulse_cnt <= 2'h0;
      r_reg.flag_armed <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // strobe B pin
  assign strobe_b_out_active = r_reg.strobe_b_out_level | (r_reg.pulse_cnt != 2'h0);
  // active level follows the invert bit
  assign STROBE_B_OUT_OUT = strobe_b_out_active ? r_reg.ctrl[`PSHP_CTRL_STROBE_B_INVERT]
                                : ~r_reg.ctrl[`PSHP_CTRL_STROBE_B_INVERT]; // R12

  //////////////////////////////////////////////////////////////////////////////
  // port C drivers
  always_comb begin
    // default: direction register and plain output data
    drv_data = r_reg.portc;
    drv_en = r_reg.dir;
    if (mode == PSHP_MODE_OUT_HS) begin
      drv_data = r_reg.latch; // R15
      if (strobe_a_in_drive) begin
        drv_en = 8'hff; // R16
      end
    end
  end

  // open-drain drives only zeros, enable is active low
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pc
      assign PORTC_OUT[gi] = drv_data[gi];
      assign PORTC_OE_N[gi] = ~(drv_en[gi]
        & ~(r_reg.ctrl[`PSHP_CTRL_OPEN_DRAIN] & drv_data[gi])); // R6
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // remaining outputs
  assign RDATA = r_reg.rdata;
  assign DATA_REG_A_OUT = r_reg.data_a;
  assign STROBE_A_IN_IRQ = r_reg.ctrl[`PSHP_CTRL_FLAG]
                  & r_reg.ctrl[`PSHP_CTRL_IRQ_EN]; // R5
  assign IRQ = |(r_reg.irq_stat & r_reg.irq_en);

endmodule

`default_nettype wire

// ### verification/pshp_port_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "pshp_params.svh"
// pin-level checks of the strobe port
module pshp_port_chk (
  // clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // register port
  input wire logic SINGLE_CHIP_MODE,
  input wire logic [`PSHP_ADDR_W-1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  // pins
  input wire logic STROBE_A_IN_IN,
  input wire logic STROBE_B_OUT_OUT,
  input wire logic [7:0] PORTC_OUT,
  input wire logic [7:0] PORTC_OE_N,
  input wire logic STROBE_A_IN_IRQ,
  input wire logic IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  // shadow of the writable control bits
  logic [6:0] cs_reg;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      cs_reg <= 7'h00;
    end else if (WR && ADDR == `PSHP_OFS_CTRL) begin
      cs_reg <= WDATA[6:0];
    end
  end
  // strobe b active two cycles, then idle
  sequence s_two(logic a);
    (STROBE_B_OUT_OUT == a) [*2] ##1 (STROBE_B_OUT_OUT != a);
  endsequence
  property p_rd_ctrl;
    $past(RD) && $past(ADDR) == `PSHP_OFS_CTRL |-> RDATA[6:0] == cs_reg;
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("ctrl readback");
  property p_irq_en;
    STROBE_A_IN_IRQ |-> cs_reg[6];
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("irq unmasked");
  property p_simple;
    WR && ADDR == `PSHP_OFS_DATA_A && !cs_reg[4] && SINGLE_CHIP_MODE
      |=> s_two(cs_reg[0]);
  endproperty
  a_simple: assert property (p_simple) else $error("simple pulse");
  property p_pulsed;
    cs_reg[4] && cs_reg[2] && SINGLE_CHIP_MODE && STROBE_B_OUT_OUT == cs_reg[0]
      && $past(STROBE_B_OUT_OUT) != cs_reg[0] |-> s_two(cs_reg[0]);
  endproperty
  a_pulsed: assert property (p_pulsed) else $error("hs pulse");
  property p_interlock;
    cs_reg[4] && !cs_reg[2] && cs_reg[6] && $past(STROBE_B_OUT_OUT) == cs_reg[0]
      && STROBE_B_OUT_OUT != cs_reg[0] |-> STROBE_A_IN_IRQ;
  endproperty
  a_interlock: assert property (p_interlock) else $error("early negate");
  property p_open_drain;
    cs_reg[5] |-> (~PORTC_OE_N & PORTC_OUT) == 8'h00;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("drove high");
  property p_out_drive;
    (cs_reg[4:3] == 2'b11 && !cs_reg[5] && SINGLE_CHIP_MODE
      && STROBE_A_IN_IN != cs_reg[1]) [*3] |-> PORTC_OE_N == 8'h00;
  endproperty
  a_out_drive: assert property (p_out_drive) else $error("no drive");
  property p_mode_gate;
    $rose(STROBE_A_IN_IRQ) && !$past(WR) |-> $past(SINGLE_CHIP_MODE);
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("flag offmode");
  property p_reset_idle;
    $past(SRST) |-> STROBE_B_OUT_OUT && PORTC_OE_N == 8'hff && !IRQ && !STROBE_A_IN_IRQ;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("reset pin");
endmodule
bind pshp_port pshp_port_chk u_chk (.CLK, .SRST, .SINGLE_CHIP_MODE,
  .ADDR, .WDATA, .WR, .RD, .RDATA, .STROBE_A_IN_IN, .STROBE_B_OUT_OUT,
  .PORTC_OUT, .PORTC_OE_N, .STROBE_A_IN_IRQ, .IRQ);
`default_nettype wire

// ### verification/pshp_far_model.sv
`timescale 1ns/100ps
`default_nettype none
// far-side peripheral: strobes a, drives or reads port c
module pshp_far_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // bench commands
  input wire logic go,
  input wire logic drv,
  input wire logic [7:0] pdata,
  // pins
  input wire logic [7:0] pc_out,
  input wire logic [7:0] pc_oe_n,
  output logic strobe_a_in,
  output logic [7:0] pc_in,
  output logic [7:0] seen
);
  logic [2:0] cnt_reg; // strobe sequence step
  logic drv_reg; // we drive port c this time
  logic [7:0] far_c;
  // our data while strobing, pull-ups otherwise
  assign far_c = (drv_reg && cnt_reg != 3'h0) ? pdata : 8'hff;
  assign pc_in = (~pc_oe_n & pc_out) | (pc_oe_n & far_c);
  // strobe a low for four cycles per request
  assign strobe_a_in = !(cnt_reg inside {[3'h1:3'h4]});
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg <= 3'h0;
      drv_reg <= 1'b0;
      seen <= 8'h00;
    end else if (go) begin
      cnt_reg <= 3'h1;
      drv_reg <= drv;
    end else if (cnt_reg != 3'h0) begin
      cnt_reg <= (cnt_reg == 3'h5) ? 3'h0 : cnt_reg + 3'h1;
      // read port c while strobe a is active
      if (cnt_reg == 3'h4) begin
        seen <= pc_in;
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "pshp_params.svh"
module testbench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic mode = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic go = 1'b0;
  logic drv = 1'b0;
  logic [`PSHP_ADDR_W-1:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] pdata = 8'h00;
  logic strobe_a_in, strobe_b_out, strobe_a_in_irq, irq;
  logic [7:0] rdata, data_reg_a, pc_in, pc_out, pc_oe_n, seen;
  logic [7:0] sp [2] = '{8'h08, 8'h01};
  int err_total = 0;
  int n_compared = 0;
  int n;
  pshp_port uut (.CLK(clk), .SRST(srst), .SINGLE_CHIP_MODE(mode),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .STROBE_A_IN_IN(strobe_a_in), .STROBE_B_OUT_OUT(strobe_b_out), .DATA_REG_A_OUT(data_reg_a),
    .PORTC_IN(pc_in), .PORTC_OUT(pc_out), .PORTC_OE_N(pc_oe_n),
    .STROBE_A_IN_IRQ(strobe_a_in_irq), .IRQ(irq));
  pshp_far_model u_far (.clk, .srst, .go, .drv, .pdata, .pc_out,
    .pc_oe_n, .strobe_a_in, .pc_in, .seen);
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      $display("mismatch %s exp %h got %h", nm, e, g);
      err_total++;
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e,
                        input string nm);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(nm, e, rdata);
  endtask
  // count cycles with strobe b at level lv
  task automatic cnt_act(input logic lv, input logic [7:0] e);
    n = 0;
    repeat (8) begin
      @(negedge clk);
      if (strobe_b_out === lv) n++;
    end
    chk("strobe_b_out cycles", e, 8'(n));
  endtask
  // one far-side strobe, then settle
  task automatic strobe(input logic [7:0] d, input logic dv);
    @(posedge clk);
    pdata <= d;
    drv <= dv;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (12) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 clk = ~clk;
  end
  // watchdog
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk("strobe_b_out rst", 8'h01, {7'h0, strobe_b_out});
    rd_reg(`PSHP_OFS_CTRL, 8'h00, "ctrl rst");
    wr_reg(`PSHP_OFS_CTRL, 8'hff);
    rd_reg(`PSHP_OFS_CTRL, 8'h7f, "ctrl ro");
    rd_reg(4'h9, 8'h00, "unmapped");
    // simple mode pulses, direction bit ignored
    foreach (sp[i]) begin
      wr_reg(`PSHP_OFS_CTRL, sp[i]);
      wr_reg(`PSHP_OFS_DATA_A, 8'h5a ^ sp[i]);
      cnt_act(sp[i][0], 8'h02);
      chk("data_reg_a", 8'h5a ^ sp[i], data_reg_a);
    end
    // simple latch, flag and interrupts
    wr_reg(`PSHP_OFS_CTRL, 8'h40);
    strobe(8'h3c, 1'b1);
    chk("strobe_a_in irq", 8'h01, {7'h0, strobe_a_in_irq});
    chk("irq masked", 8'h00, {7'h0, irq});
    rd_reg(`PSHP_OFS_LATCH, 8'h3c, "latch");
    rd_reg(`PSHP_OFS_CTRL, 8'hc0, "flag kept");
    rd_reg(`PSHP_OFS_LATCH, 8'h3c, "latch");
    rd_reg(`PSHP_OFS_CTRL, 8'h40, "flag clr");
    wr_reg(`PSHP_OFS_IRQ_EN, 8'h01);
    @(negedge clk);
    chk("irq on", 8'h01, {7'h0, irq});
    wr_reg(`PSHP_OFS_IRQ_CLR, 8'h03);
    rd_reg(`PSHP_OFS_IRQ_STAT, 8'h00, "stat clr");
    rd_reg(`PSHP_OFS_IRQ_CLR, 8'h00, "clr reads");
    chk("irq off", 8'h00, {7'h0, irq});
    wr_reg(`PSHP_OFS_IRQ_EN, 8'h00);
    // input handshake, interlocked
    wr_reg(`PSHP_OFS_CTRL, 8'h50);
    @(negedge clk);
    chk("ready", 8'h00, {7'h0, strobe_b_out});
    strobe(8'ha5, 1'b1);
    chk("negated", 8'h01, {7'h0, strobe_b_out});
    rd_reg(`PSHP_OFS_IRQ_STAT, 8'h03, "stat hs");
    rd_reg(`PSHP_OFS_CTRL, 8'hd0, "flag hs");
    rd_reg(`PSHP_OFS_LATCH, 8'ha5, "latch hs");
    @(negedge clk);
    chk("reassert", 8'h00, {7'h0, strobe_b_out});
    // input handshake, pulsed, active high
    wr_reg(`PSHP_OFS_CTRL, 8'h01);
    wr_reg(`PSHP_OFS_CTRL, 8'h15);
    cnt_act(1'b1, 8'h02);
    // output handshake, rising edge, low enables drivers
    wr_reg(`PSHP_OFS_CTRL, 8'h1a);
    wr_reg(`PSHP_OFS_LATCH, 8'hc3);
    @(negedge clk);
    chk("data ready", 8'h00, {7'h0, strobe_b_out});
    chk("idle oe", 8'hff, pc_oe_n);
    strobe(8'h00, 1'b0);
    chk("seen", 8'hc3, seen);
    chk("ack", 8'h01, {7'h0, strobe_b_out});
    rd_reg(`PSHP_OFS_CTRL, 8'h9a, "flag out");
    wr_reg(`PSHP_OFS_LATCH, 8'h00);
    rd_reg(`PSHP_OFS_CTRL, 8'h1a, "flag out clr");
    // open-drain port c
    wr_reg(`PSHP_OFS_CTRL, 8'h20);
    wr_reg(`PSHP_OFS_DIR, 8'hff);
    wr_reg(`PSHP_OFS_PORTC, 8'h0f);
    @(negedge clk);
    chk("od oe", 8'h0f, pc_oe_n);
    rd_reg(`PSHP_OFS_PORTC, 8'h0f, "pins");
    wr_reg(`PSHP_OFS_CTRL, 8'h00);
    @(negedge clk);
    chk("pp oe", 8'h00, pc_oe_n);
    wr_reg(`PSHP_OFS_DIR, 8'h00);
    // edges ignored outside single-chip mode
    @(posedge clk);
    mode <= 1'b0;
    wr_reg(`PSHP_OFS_CTRL, 8'h40);
    strobe(8'h11, 1'b1);
    rd_reg(`PSHP_OFS_CTRL, 8'h40, "no flag");
    @(posedge clk);
    mode <= 1'b1;
    tally_and_finish();
  end
endmodule
`default_nettype wire
